/* hw/sbw_rate_map.vh */
`ifndef SBW_RATE_MAP_VH
`define SBW_RATE_MAP_VH

// register byte offsets on the apb bus
`define SBW_OFS_DIV_LOW      12'h000
`define SBW_OFS_DIV_HIGH     12'h004
`define SBW_OFS_CONTROL      12'h008
`define SBW_OFS_RX_DATA      12'h00C

// baud_control_reg field positions
`define SBW_BIT_WIDE         0
`define SBW_BIT_HSPEED       1
`define SBW_BIT_ABD_EN       2
`define SBW_BIT_WAKE_EN      3
`define SBW_BIT_ABD_OVF      4
`define SBW_BIT_SYNC         5
`define SBW_BIT_RX_IDLE      6
`define SBW_BIT_RX_PEND      7

// reset values
`define SBW_RST_DIVISOR      8'h00
`define SBW_RST_CONTROL      8'h00

// base clock divisions of the system clock
`define SBW_DIV_SLOW         10'd64
`define SBW_DIV_MID          10'd16
`define SBW_DIV_FAST         10'd4
// measurement clock runs at one eighth of the base clock
`define SBW_ABD_SHIFT        3
// rising edges in a sync character
`define SBW_SYNC_RISES       3'd5

`endif

/* hw/sbw_rate_gen.v */
// Notes on behaviour
// - 8-bit divider default, 16-bit when wide
// - base clock fosc/64, /16, or /4
// - synchronous mode ignores high-speed select
// - bit rate is base over divisor+1
// - divisor write clears the divider counter
// - autobaud enable measures sync, holds receiver idle
// - count from one, first to fifth rise
// - fifth rise keeps count, clears enable, pends
// - reading receive data clears pending flag
// - autobaud uses 16 bits at eighth rate
// - measurement clock fosc/512, /128, /128, /32
// - overflow sets flags, counting continues
// - idle low until fifth rise, re-pend
// - clearing enable early resumes normal reception
// - wake only asynchronous; divider stops in sleep
// - wake enable blocks reception, watches falls
// - wake fall sets pending; read clears it
// - rise ending break clears wake enable
// - non-zero character wakes on first low
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/10ps
`include "sbw_rate_map.vh"

module sbw_rate_gen
(
   // clock and reset
   input  wire        pclk,
   input  wire        presetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // serial pin
   input  wire        serial_rx_line,
   // core state
   input  wire        sleep_mode,
   // receiver shift logic
   input  wire        rx_char_valid,
   input  wire [7:0]  rx_char,
   input  wire        rx_shift_idle,
   output reg         rate_tick,
   output reg         rx_normal_enable,
   output reg         autobaud_measure,
   output reg         receive_pending_flag,
   output reg         receiver_idle_flag
);

   localparam ST_IDLE  = 2'd0;
   localparam ST_START = 2'd1;
   localparam ST_RISE1 = 2'd2;
   localparam ST_COUNT = 2'd3;

   localparam WK_IDLE  = 1'b0;
   localparam WK_LOW   = 1'b1;

   // base clock division for the select bits
   function [9:0] base_div;
      input wide;
      input hs;
      begin
         if (wide && hs)
            base_div = `SBW_DIV_FAST;
         else if (wide || hs)
            base_div = `SBW_DIV_MID;
         else
            base_div = `SBW_DIV_SLOW;
      end
   endfunction

   reg  [7:0]  rate_divisor_low;
   reg  [7:0]  rate_divisor_high;
   reg         wide_count_select;
   reg         high_speed_select;
   reg         autobaud_enable;
   reg         wake_on_break_enable;
   reg         autobaud_overflow_flag;
   reg         sync_mode;
   reg  [7:0]  receive_data_reg;

   reg         rx_s1;
   reg         rx_s2;
   reg         rx_s3;
   reg         rx_level;
   reg  [1:0]  abd_state;
   reg  [2:0]  rise_count;
   reg         wake_state;
   reg  [12:0] presc;
   reg  [15:0] rate_count;

   wire        apb_access;
   wire        apb_write;
   wire        apb_read;
   wire        wr_low;
   wire        wr_high;
   wire        wr_ctrl;
   wire        rd_data;
   wire        rx_fall;
   wire        rx_rise;
   wire        eff_hs;
   wire [9:0]  base_period;
   wire [12:0] presc_limit;
   wire        presc_done;
   wire        measuring;
   wire        last_rise;
   wire [15:0] divisor_pair;
   wire [15:0] div_limit;
   wire [16:0] pair_inc;

   assign apb_access = psel & penable & pready;
   assign apb_write  = apb_access & pwrite;
   assign apb_read   = apb_access & ~pwrite;
   assign wr_low     = apb_write && (paddr == `SBW_OFS_DIV_LOW);
   assign wr_high    = apb_write && (paddr == `SBW_OFS_DIV_HIGH);
   assign wr_ctrl    = apb_write && (paddr == `SBW_OFS_CONTROL);
   assign rd_data    = apb_read && (paddr == `SBW_OFS_RX_DATA);

   // line changes count once the second and third stages agree
   assign rx_fall = rx_level & ~rx_s3 & ~rx_s2;
   assign rx_rise = ~rx_level & rx_s3 & rx_s2;

   assign eff_hs       = high_speed_select & ~sync_mode;
   assign base_period  = base_div(wide_count_select, eff_hs);
   assign measuring    = (abd_state == ST_COUNT);
   assign presc_limit  = measuring ?
                         ({3'b000, base_period} << `SBW_ABD_SHIFT) :
                         {3'b000, base_period};
   // limit shrinks when a measurement ends or the selects change;
   // a count already past it reloads at once instead of wrapping
   assign presc_done   = (presc >= presc_limit - 13'd1);
   assign last_rise    = measuring && rx_rise &&
                         (rise_count == `SBW_SYNC_RISES);
   assign divisor_pair = {rate_divisor_high, rate_divisor_low};
   assign div_limit    = wide_count_select ? divisor_pair :
                         {8'h00, rate_divisor_low};
   assign pair_inc     = {1'b0, divisor_pair} + 17'd1;

   // pin synchroniser and filtered level
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rx_s1    <= 1'b1;
         rx_s2    <= 1'b1;
         rx_s3    <= 1'b1;
         rx_level <= 1'b1;
      end
      else
      begin
         rx_s1 <= serial_rx_line;
         rx_s2 <= rx_s1;
         rx_s3 <= rx_s2;
         if (rx_s2 == rx_s3)
            rx_level <= rx_s3;
      end
   end

   // apb answer: zero wait, error on unmapped offsets
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end
      else
      begin
         // no wait states once out of reset
         pready <= 1'b1;
         if (psel && !penable)
         begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (paddr == `SBW_OFS_DIV_LOW)
               prdata <= {24'h00_0000, rate_divisor_low};
            else if (paddr == `SBW_OFS_DIV_HIGH)
               prdata <= {24'h00_0000, rate_divisor_high};
            else if (paddr == `SBW_OFS_CONTROL)
               prdata <= {24'h00_0000, receive_pending_flag,
                          receiver_idle_flag, sync_mode,
                          autobaud_overflow_flag, wake_on_break_enable,
                          autobaud_enable, high_speed_select,
                          wide_count_select};
            else if (paddr == `SBW_OFS_RX_DATA)
               prdata <= {24'h00_0000, receive_data_reg};
            else
               pslverr <= 1'b1;
         end
      end
   end

   // control, divisor pair, measurement and wake sequences
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rate_divisor_low       <= `SBW_RST_DIVISOR;
         rate_divisor_high      <= `SBW_RST_DIVISOR;
         wide_count_select      <= 1'b0;
         high_speed_select      <= 1'b0;
         autobaud_enable        <= 1'b0;
         wake_on_break_enable   <= 1'b0;
         autobaud_overflow_flag <= 1'b0;
         sync_mode              <= 1'b0;
         receive_data_reg       <= 8'h00;
         receive_pending_flag   <= 1'b0;
         abd_state              <= ST_IDLE;
         rise_count             <= 3'd0;
         wake_state             <= WK_IDLE;
      end
      else
      begin
         if (wr_low)
            rate_divisor_low <= pwdata[7:0];
         if (wr_high)
            rate_divisor_high <= pwdata[7:0];
         if (wr_ctrl)
         begin
            wide_count_select    <= pwdata[`SBW_BIT_WIDE];
            high_speed_select    <= pwdata[`SBW_BIT_HSPEED];
            autobaud_enable      <= pwdata[`SBW_BIT_ABD_EN];
            wake_on_break_enable <= pwdata[`SBW_BIT_WAKE_EN] &
                                    ~pwdata[`SBW_BIT_SYNC];
            sync_mode            <= pwdata[`SBW_BIT_SYNC];
            if (!pwdata[`SBW_BIT_ABD_OVF])
               autobaud_overflow_flag <= 1'b0;
         end
         // any set further down wins over this clear
         if (rd_data)
            receive_pending_flag <= 1'b0;
         if (rx_char_valid && !autobaud_measure)
         begin
            receive_data_reg     <= rx_char;
            receive_pending_flag <= 1'b1;
         end

         // wake on break, ahead of any measurement
         case (wake_state)
            // any fall counts, break or ordinary start bit
            WK_IDLE:
               if (wake_on_break_enable && rx_fall)
               begin
                  receive_pending_flag <= 1'b1;
                  wake_state           <= WK_LOW;
               end
            // waiting for the rise that ends the break
            default:
               if (!wake_on_break_enable)
                  wake_state <= WK_IDLE;
               else if (rx_rise)
               begin
                  wake_on_break_enable <= 1'b0;
                  wake_state           <= WK_IDLE;
               end
         endcase

         // measurement of the sync character
         if (!autobaud_enable)
            abd_state <= ST_IDLE;
         else
         begin
            case (abd_state)
               ST_IDLE:
                  if (!wake_on_break_enable)
                     abd_state <= ST_START;
               ST_START:
                  if (rx_fall)
                     abd_state <= ST_RISE1;
               // first rise after the start bit: pair restarts at one
               ST_RISE1:
                  if (rx_rise)
                  begin
                     rate_divisor_low  <= 8'h01;
                     rate_divisor_high <= 8'h00;
                     rise_count        <= 3'd2;
                     abd_state         <= ST_COUNT;
                  end
               default:
               begin
                  // one step per eight base periods
                  if (presc_done && !sleep_mode)
                  begin
                     rate_divisor_low  <= pair_inc[7:0];
                     rate_divisor_high <= pair_inc[15:8];
                     if (pair_inc[16])
                     begin
                        autobaud_overflow_flag <= 1'b1;
                        receive_pending_flag   <= 1'b1;
                     end
                  end
                  if (rx_rise)
                     rise_count <= rise_count + 3'd1;
                  if (last_rise)
                  begin
                     autobaud_enable      <= 1'b0;
                     receive_pending_flag <= 1'b1;
                     abd_state            <= ST_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // base prescaler and rate divider
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         presc      <= 13'd0;
         rate_count <= 16'h0000;
         rate_tick  <= 1'b0;
      end
      else
      begin
         rate_tick <= 1'b0;
         // new divisor takes effect without waiting for the old period
         if (wr_low || wr_high)
         begin
            presc      <= 13'd0;
            rate_count <= 16'h0000;
         end
         else if (sleep_mode)
            presc <= 13'd0;
         else if (presc_done)
         begin
            presc <= 13'd0;
            if (!autobaud_measure)
            begin
               if (rate_count >= div_limit)
               begin
                  rate_count <= 16'h0000;
                  rate_tick  <= 1'b1;
               end
               else
                  rate_count <= rate_count + 16'h0001;
            end
         end
         else
            presc <= presc + 13'd1;
      end
   end

   // status toward the receiver shift logic
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         autobaud_measure   <= 1'b0;
         rx_normal_enable   <= 1'b0;
         receiver_idle_flag <= 1'b1;
      end
      else
      begin
         // measurement releases the receiver on the fifth rise itself
         autobaud_measure   <= autobaud_enable & ~wake_on_break_enable &
                               ~last_rise;
         rx_normal_enable   <= ~autobaud_enable & ~wake_on_break_enable &
                               ~sleep_mode;
         receiver_idle_flag <= rx_shift_idle &
                               (~autobaud_enable | last_rise |
                                wake_on_break_enable);
      end
   end

endmodule

/* testbench/sbw_checker.sv */
`timescale 1ns/10ps
`include "sbw_rate_map.vh"

module sbw_checker
(
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire        pready,
   input wire [11:0] paddr,
   // core and receiver side
   input wire        sleep_mode,
   input wire        rx_char_valid,
   // watched outputs
   input wire        rate_tick,
   input wire        rx_normal_enable,
   input wire        autobaud_measure,
   input wire        receive_pending_flag,
   input wire        receiver_idle_flag
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   wire acc    = psel && penable && pready;
   wire sw_wr  = acc && pwrite;
   wire div_wr = sw_wr && (paddr == `SBW_OFS_DIV_LOW
                 || paddr == `SBW_OFS_DIV_HIGH);
   wire rx_rd  = acc && !pwrite && paddr == `SBW_OFS_RX_DATA;

   a_tick_gap: assert property ($rose(rate_tick) |=> !rate_tick [*3])
      else $error("tick gap too short");
   a_div_clear: assert property (div_wr |=> ##1 !rate_tick [*2])
      else $error("tick soon after divisor write");
   a_sleep_halt: assert property (sleep_mode ##1 sleep_mode
      |-> !rate_tick)
      else $error("tick in sleep");
   a_sleep_block: assert property (sleep_mode |=> !rx_normal_enable)
      else $error("reception on in sleep");
   a_abd_hold: assert property (autobaud_measure |-> !rx_normal_enable)
      else $error("reception on in autobaud");
   a_abd_busy: assert property (autobaud_measure
      && $past(autobaud_measure) |-> !receiver_idle_flag)
      else $error("idle during autobaud");
   a_abd_done: assert property ($fell(autobaud_measure)
      && !$past(sw_wr, 2) |-> receive_pending_flag && receiver_idle_flag)
      else $error("autobaud end without pending and idle");
   a_read_clear: assert property (rx_rd && !rx_char_valid
      && rx_normal_enable |=> !receive_pending_flag)
      else $error("pending kept after receive read");

   c_tick: cover property (rate_tick);
   c_abd_end: cover property ($fell(autobaud_measure));
   c_sleep: cover property (sleep_mode ##1 sleep_mode);
endmodule

/* testbench/sbw_remote_tx.sv */
`timescale 1ns/10ps

module sbw_remote_tx
(
   // clock
   input wire         pclk,
   // frame request
   input wire         go,
   input wire         brk,
   input wire  [7:0]  data,
   input wire  [15:0] bit_len,
   // serial line and status
   output logic       line,
   output logic       busy
);
   logic [14:0] frame;
   int          nb;

   initial
   begin
      line = 1'b1;
      busy = 1'b0;
      forever
      begin
         @(posedge pclk);
         if (go)
         begin
            // break is start plus 13 low bits, then high
            frame = brk ? 15'h4000 : {6'h3F, data, 1'b0};
            nb = brk ? 15 : 10;
            busy <= 1'b1;
            for (int i = 0; i < nb; i++)
            begin
               line <= frame[i];
               repeat (bit_len) @(posedge pclk);
            end
            busy <= 1'b0;
         end
      end
   end
endmodule

/* testbench/testbench.sv */
`timescale 1ns/10ps
`include "sbw_rate_map.vh"

module testbench;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        serial_rx_line;
   logic        sleep_mode;
   logic        rx_char_valid;
   logic [7:0]  rx_char;
   logic        rate_tick;
   logic        rx_normal_enable;
   logic        autobaud_measure;
   logic        receive_pending_flag;
   logic        receiver_idle_flag;
   logic        go;
   logic        brk;
   logic [15:0] bit_len;
   logic        busy;
   logic [31:0] rdata;
   logic        rerr;
   logic [15:0] pair;
   int          errors;
   int          cmp_count;
   int          n;
   logic [7:0]  modes [5] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h22};
   logic [31:0] periods [5] = '{192, 48, 4144, 1036, 192};

   sbw_rate_gen i_sbw_rate_gen (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .serial_rx_line,
      .sleep_mode, .rx_char_valid, .rx_char, .rx_shift_idle(1'b1),
      .rate_tick, .rx_normal_enable, .autobaud_measure,
      .receive_pending_flag, .receiver_idle_flag);
   sbw_remote_tx i_sbw_remote_tx (.pclk, .go, .brk, .data(8'h55),
      .bit_len, .line(serial_rx_line), .busy);

   task automatic chk(input string nm, input logic [31:0] exp, got);
      cmp_count++;
      if (got !== exp)
      begin
         errors++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic complete_run;
      $display("compares %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic hang(input string nm);
      errors++;
      $display("FAIL %s expected done seen timeout", nm);
      complete_run;
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      if (pready !== 1'b1) hang("pready");
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic next_tick(output int c);
      c = 0;
      do
      begin
         @(posedge pclk);
         c++;
      end
      while (rate_tick !== 1'b1 && c < 9000);
      if (rate_tick !== 1'b1) hang("rate_tick");
   endtask

   task automatic launch(input logic b, input logic [15:0] l);
      brk <= b;
      bit_len <= l;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wait_frame;
      n = 0;
      while (busy === 1'b1 && n < 60000)
      begin
         @(posedge pclk);
         n++;
      end
      if (busy === 1'b1) hang("frame");
   endtask

   initial
   begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   initial
   begin
      {presetn, psel, penable, pwrite, sleep_mode, rx_char_valid} = 6'h00;
      {go, brk, paddr, pwdata, rx_char, bit_len} = 70'h0;
      errors = 0;
      cmp_count = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `SBW_OFS_CONTROL, 32'h0000_0000);
      chk("control", 32'h0000_0040, rdata);
      rx_char <= 8'hA5;
      rx_char_valid <= 1'b1;
      @(posedge pclk);
      rx_char_valid <= 1'b0;
      repeat (2) @(posedge pclk);
      apb(1'b0, `SBW_OFS_CONTROL, 32'h0000_0000);
      chk("pending", 32'h0000_00C0, rdata);
      apb(1'b0, `SBW_OFS_RX_DATA, 32'h0000_0000);
      chk("rx_data", 32'h0000_00A5, rdata);
      apb(1'b0, `SBW_OFS_CONTROL, 32'h0000_0000);
      chk("read_clear", 32'h0000_0040, rdata);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk("slverr", 32'h0000_0001, {31'h0000_0000, rerr});
      for (int i = 0; i < 5; i++)
      begin
         apb(1'b1, `SBW_OFS_CONTROL, {24'h00_0000, modes[i]});
         apb(1'b1, `SBW_OFS_DIV_HIGH, 32'h0000_0001);
         apb(1'b1, `SBW_OFS_DIV_LOW, 32'h0000_0002);
         next_tick(n);
         next_tick(n);
         chk("period", periods[i], n);
      end
      sleep_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      n = 0;
      repeat (400)
      begin
         @(posedge pclk);
         if (rate_tick === 1'b1) n++;
      end
      chk("sleep_ticks", 32'h0000_0000, n);
      sleep_mode <= 1'b0;
      // sync character at 4160 cycles a bit, measured at pclk/128
      apb(1'b1, `SBW_OFS_CONTROL, 32'h0000_0006);
      launch(1'b0, 16'h1040);
      wait_frame;
      apb(1'b0, `SBW_OFS_DIV_LOW, 32'h0000_0000);
      pair[7:0] = rdata[7:0];
      apb(1'b0, `SBW_OFS_DIV_HIGH, 32'h0000_0000);
      pair[15:8] = rdata[7:0];
      chk("abd_pair", 1, pair == 16'h0104 || pair == 16'h0105);
      apb(1'b0, `SBW_OFS_CONTROL, 32'h0000_0000);
      chk("abd_ctrl", 32'h0000_00C2, rdata);
      apb(1'b0, `SBW_OFS_RX_DATA, 32'h0000_0000);
      apb(1'b0, `SBW_OFS_CONTROL, 32'h0000_0000);
      chk("abd_clear", 32'h0000_0042, rdata);
      apb(1'b1, `SBW_OFS_CONTROL, 32'h0000_0001);
      pair = pair - 16'h0001;
      apb(1'b1, `SBW_OFS_DIV_HIGH, {24'h00_0000, pair[15:8]});
      apb(1'b1, `SBW_OFS_DIV_LOW, {24'h00_0000, pair[7:0]});
      next_tick(n);
      next_tick(n);
      chk("abd_rate", 1, n == 4160 || n == 4176);
      apb(1'b1, `SBW_OFS_CONTROL, 32'h0000_0008);
      launch(1'b1, 16'h00A0);
      repeat (39) @(posedge pclk);
      apb(1'b0, `SBW_OFS_CONTROL, 32'h0000_0000);
      chk("wake_pend", 32'h0000_0088, rdata & 32'h0000_0088);
      chk("rx_normal", 32'h0000_0000, rx_normal_enable);
      wait_frame;
      apb(1'b0, `SBW_OFS_CONTROL, 32'h0000_0000);
      chk("wake_end", 32'h0000_0080, rdata & 32'h0000_0088);
      apb(1'b0, `SBW_OFS_RX_DATA, 32'h0000_0000);
      apb(1'b0, `SBW_OFS_CONTROL, 32'h0000_0000);
      chk("wake_clear", 32'h0000_0000, rdata & 32'h0000_0080);
      complete_run;
   end
endmodule

bind sbw_rate_gen sbw_checker i_sbw_checker (.pclk, .presetn, .psel,
   .penable, .pwrite, .pready, .paddr, .sleep_mode, .rx_char_valid,
   .rate_tick, .rx_normal_enable, .autobaud_measure,
   .receive_pending_flag, .receiver_idle_flag);
